/* bench/cjl_exec_tb_top.sv */
// Purpose: self-checking bench of cjl_exec against an integer model
// Assumes: the bench answers the memory port itself, with a random ack delay of 0..3 cycles
// Notes:   assertions live in the design files; undefined result bits are masked, not checked
module cjl_exec_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic             clk;
  logic             rst;
  logic             issue_valid;
  cjl_pkg::cjl_op_t issue_op;
  logic [7:0]       short_displacement;
  logic [15:0]      instr_ptr;
  logic [15:0]      effective_address;
  logic [2:0]       dest_sel;
  logic [15:0]      frame_base_ptr;
  logic             overflow_flag, parity_flag, sign_flag;
  logic             zero_flag, aux_carry_flag, carry_flag;
  logic [15:0]      mem_rd_data;
  logic             mem_rd_ack;
  logic             busy_q, done_q, mem_rd_req_q, instr_ptr_we_q, jump_taken_q;
  logic             gp_we_q, high_acc_we_q, data_segment_we_q, frame_base_we_q;
  logic             stack_ptr_we_q, flags_we_q;
  logic [15:0]      mem_addr_q, instr_ptr_new_q, gp_data_q, data_segment_reg_q;
  logic [15:0]      frame_base_new_q, stack_ptr_new_q;
  logic [2:0]       gp_sel_q;
  logic [7:0]       high_acc_byte_q;
  int               error_cnt;
  int               total_checks;
  int               n_ip, n_gp, n_ds, n_bp, n_ha, n_done, n_req, flag_bad, busy_seen;
  logic [15:0]      got_ip, got_gp, got_ds, got_bp;
  logic [7:0]       got_ha;
  logic [2:0]       got_sel;
  logic             got_tk;
  logic [15:0]      sp_q[$];
  logic [15:0]      ad_q[$];

  cjl_exec cjl_exec_i (
    .clk, .rst, .issue_valid, .issue_op, .short_displacement, .instr_ptr,
    .effective_address, .dest_sel, .frame_base_ptr, .overflow_flag, .parity_flag,
    .sign_flag, .zero_flag, .aux_carry_flag, .carry_flag, .mem_rd_data, .mem_rd_ack,
    .busy_q, .done_q, .mem_rd_req_q, .mem_addr_q, .instr_ptr_we_q, .jump_taken_q,
    .instr_ptr_new_q, .gp_we_q, .gp_sel_q, .gp_data_q, .high_acc_we_q, .high_acc_byte_q,
    .data_segment_we_q, .data_segment_reg_q, .frame_base_we_q, .frame_base_new_q,
    .stack_ptr_we_q, .stack_ptr_new_q, .flags_we_q
  );

  // ----------------------------------------
  // model helpers
  // ----------------------------------------
  // memory content: a scramble of the address so a wrong word never matches by luck
  function automatic logic [15:0] mem_word(input logic [15:0] a);
    return {a[7:0], a[15:8]} ^ 16'ha5c3;
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ----------------------------------------
  // one instruction: issue, serve memory, collect strobes
  // ----------------------------------------
  // poke offers a second instruction while busy; it must be dropped silently
  task automatic run_op(input cjl_pkg::cjl_op_t op, input logic poke);
    int n;
    int wait_n;
    int dly;
    n_ip = 0; n_gp = 0; n_ds = 0; n_bp = 0; n_ha = 0; n_done = 0; n_req = 0;
    flag_bad = 0; busy_seen = 0; wait_n = 0;
    sp_q.delete();
    ad_q.delete();
    dly = $urandom_range(3);
    @(posedge clk);
    #1;
    issue_op = op;
    issue_valid = 1'b1;
    @(posedge clk);
    #1;
    for (n = 0; n < 40 && n_done == 0; n++) begin
      issue_valid = poke && n == 0;
      if (poke && n == 0) issue_op = cjl_pkg::OP_LOAD_EFF_ADDR;
      if (n == 0 && busy_q === 1'b1) busy_seen = 1;
      if (instr_ptr_we_q) begin
        n_ip++; got_ip = instr_ptr_new_q; got_tk = jump_taken_q;
      end
      if (gp_we_q) begin
        n_gp++; got_gp = gp_data_q; got_sel = gp_sel_q;
      end
      if (high_acc_we_q) begin
        n_ha++; got_ha = high_acc_byte_q;
      end
      if (data_segment_we_q) begin
        n_ds++; got_ds = data_segment_reg_q;
      end
      if (frame_base_we_q) begin
        n_bp++; got_bp = frame_base_new_q;
      end
      if (stack_ptr_we_q) sp_q.push_back(stack_ptr_new_q);
      if (flags_we_q !== 1'b0) flag_bad = 1;
      if (mem_rd_req_q) n_req++;
      if (done_q) n_done++;
      if (mem_rd_req_q && !mem_rd_ack && wait_n >= dly) begin
        ad_q.push_back(mem_addr_q);
        mem_rd_ack = 1'b1;
        mem_rd_data = mem_word(mem_addr_q);
        wait_n = 0;
      end else begin
        if (mem_rd_req_q) wait_n++;
        mem_rd_ack = 1'b0;
        // released data line: never keeps the last word
        mem_rd_data = ~mem_rd_data;
      end
      if (!done_q) begin
        @(posedge clk);
        #1;
      end
    end
    chk(16'(flag_bad), 16'h0000, "flags written");
    chk({15'h0000, busy_q}, 16'h0000, "busy at done");
    chk(16'(n_done), 16'h0001, "completion within bound");
    if (n_done == 0) finish_test();
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    logic        cond;
    logic [15:0] ea;
    int          i;
    rst = 1'b1; issue_valid = 1'b0; issue_op = cjl_pkg::OP_JUMP_IF_OVERFLOW;
    short_displacement = 8'h00; instr_ptr = 16'h0000; effective_address = 16'h0000;
    dest_sel = 3'h0; frame_base_ptr = 16'h0000; mem_rd_data = 16'h0000; mem_rd_ack = 1'b0;
    {overflow_flag, parity_flag, sign_flag, zero_flag, aux_carry_flag, carry_flag} = 6'h00;
    error_cnt = 0;
    total_checks = 0;
    void'($urandom(68));
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    // ----------------------------------------
    // short conditional jumps, both outcomes, displacement 8'h80 taken, 8'h7f only untaken
    // ----------------------------------------
    for (i = 0; i < 16; i++) begin
      {overflow_flag, parity_flag, sign_flag, zero_flag, aux_carry_flag, carry_flag} = 6'($urandom);
      case (i % 4)
        0: overflow_flag = i[2];
        1, 2: parity_flag = i[2];
        default: sign_flag = i[2];
      endcase
      short_displacement = (i < 4) ? 8'h7f : ((i < 8) ? 8'h80 : 8'($urandom));
      instr_ptr = 16'($urandom);
      cond = i[2];
      run_op(cjl_pkg::cjl_op_t'(3'(i % 4)), 1'b0);
      chk(16'(n_ip), 16'h0001, "jump strobes");
      chk({15'h0000, got_tk}, {15'h0000, cond}, "jump taken");
      chk(got_ip, instr_ptr + 16'h0002 + (cond ? {{8{short_displacement[7]}},
          short_displacement} : 16'h0000), "jump target");
    end
    $display("test jumps done");
    // ----------------------------------------
    // flags into the high accumulator byte
    // ----------------------------------------
    for (i = 0; i < 6; i++) begin
      {overflow_flag, parity_flag, sign_flag, zero_flag, aux_carry_flag, carry_flag} = 6'($urandom);
      run_op(cjl_pkg::OP_FLAGS_TO_HIGH_ACC, 1'b0);
      chk(16'(n_ha), 16'h0001, "flag copy strobes");
      chk({8'h00, got_ha & 8'hd5}, {8'h00, sign_flag, zero_flag, 1'b0, aux_carry_flag,
          1'b0, parity_flag, 1'b0, carry_flag}, "flag copy");
    end
    $display("test flag copy done");
    // ----------------------------------------
    // effective address: offset only, no read
    // ----------------------------------------
    for (i = 0; i < 4; i++) begin
      dest_sel = 3'(i * 3);
      effective_address = 16'($urandom);
      run_op(cjl_pkg::OP_LOAD_EFF_ADDR, 1'b0);
      chk(16'(n_gp), 16'h0001, "ea strobes");
      chk(got_gp, effective_address, "ea value");
      chk({13'h0000, got_sel}, {13'h0000, dest_sel}, "ea dest");
      chk(16'(n_req), 16'h0000, "ea read cycles");
    end
    $display("test effective address done");
    // ----------------------------------------
    // far pointer through data segment, every destination, refused issue
    // ----------------------------------------
    for (i = 0; i < 8; i++) begin
      dest_sel = 3'(i);
      ea = (i == 7) ? 16'hfffe : 16'($urandom);
      effective_address = ea;
      run_op(cjl_pkg::OP_LOAD_FAR_PTR_DATA_SEG, i[0]);
      chk(16'(busy_seen), 16'h0001, "far pointer busy");
      chk(16'(ad_q.size()), 16'h0002, "far pointer reads");
      chk(ad_q[0], ea, "offset address");
      chk(ad_q[1], ea + 16'h0002, "segment address");
      chk(16'(n_gp), 16'h0001, "offset strobes");
      chk(got_gp, mem_word(ea), "offset word");
      chk({13'h0000, got_sel}, {13'h0000, dest_sel}, "offset dest");
      chk(16'(n_ds), 16'h0001, "segment strobes");
      chk(got_ds, mem_word(ea + 16'h0002), "segment word");
      chk(16'(sp_q.size()), 16'h0000, "far pointer stack strobes");
    end
    $display("test far pointer done");
    // ----------------------------------------
    // frame teardown
    // ----------------------------------------
    for (i = 0; i < 4; i++) begin
      frame_base_ptr = (i == 3) ? 16'hfffe : 16'($urandom);
      run_op(cjl_pkg::OP_FRAME_TEARDOWN, 1'b0);
      chk(16'(sp_q.size()), 16'h0002, "stack strobes");
      chk(sp_q[0], frame_base_ptr, "stack copy");
      chk(ad_q[0], frame_base_ptr, "pop address");
      chk(16'(n_bp), 16'h0001, "frame strobes");
      chk(got_bp, mem_word(frame_base_ptr), "popped frame");
      chk(sp_q[1], frame_base_ptr + 16'h0002, "stack after pop");
      chk(16'(ad_q.size()), 16'h0001, "pop reads");
      chk(16'(busy_seen), 16'h0001, "teardown busy");
    end
    $display("test teardown done");
    finish_test();
  end
endmodule

/* hdl/cjl_branch.sv */
// Purpose: condition test and target of the short conditional jumps
// Assumes: instr_ptr holds the address of the jump itself
// Notes:   purely combinational
`include "cjl_defs.svh"

module cjl_branch (
  cjl_xu_if.br xu
);

  function automatic logic [15:0] sext8(input logic [7:0] v);
    sext8 = {{8{v[7]}}, v};
  endfunction

  logic        cond;
  logic [15:0] next_instr;

  always_comb begin
    unique case (xu.op)
      cjl_pkg::OP_JUMP_IF_OVERFLOW:    cond = xu.overflow_flag;
      cjl_pkg::OP_JUMP_IF_PARITY,
      cjl_pkg::OP_JUMP_IF_PARITY_EVEN: cond = xu.parity_flag;
      cjl_pkg::OP_JUMP_IF_SIGN:        cond = xu.sign_flag;
      default:                         cond = 1'b0;
    endcase
  end

  // displacement counts from the byte after the two-byte jump
  assign next_instr = xu.instr_ptr + `CJL_INSTR_LEN;
  assign xu.taken   = cond;
  assign xu.target  = cond ? next_instr + sext8(xu.short_displacement)
                           : next_instr;

endmodule

/* hdl/cjl_defs.svh */
// Purpose: constants of the conditional jump and load execution block
// Assumes: included by bare name
// Notes:   definitions only
`ifndef CJL_DEFS_SVH
`define CJL_DEFS_SVH

// ----------------------------------------
// address steps
// ----------------------------------------
`define CJL_INSTR_LEN  16'h0002
`define CJL_SEG_OFS    16'h0002
`define CJL_POP_INC    16'h0002

// ----------------------------------------
// high accumulator byte layout
// ----------------------------------------
`define CJL_HA_SIGN    7
`define CJL_HA_ZERO    6
`define CJL_HA_AUX     4
`define CJL_HA_PAR     2
`define CJL_HA_CARRY   0
`define CJL_HA_FILL    8'h00

// ----------------------------------------
// reset values
// ----------------------------------------
`define CJL_RST16      16'h0000
`define CJL_RST8       8'h00
`define CJL_RST3       3'h0

`endif

/* hdl/cjl_exec.sv */
// Purpose: execution of short conditional jumps and pointer/frame loads
// Assumes: decoder, register file and memory port all on clk
// Notes:   results leave as one-cycle write strobes with data
//
// Function
// - overflow jump taken only when overflow set
// - parity jump, both names, taken when parity set
// - sign jump taken only when sign set
// - taken jump adds sign-extended displacement
// - sign,zero,aux,parity,carry into bits 7,6,4,2,0
// - bits 5,3,1 of that byte undefined
// - far pointer: offset to register, segment to data segment
// - far pointer source memory, any 16-bit destination
// - effective address written, no data read
// - teardown first copies frame base into stack
// - then pops frame base, stack up by two
// - no instruction here alters any flag
`include "cjl_defs.svh"

module cjl_exec (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             issue_valid,
  input  wire cjl_pkg::cjl_op_t issue_op,
  input  wire logic [7:0]       short_displacement,
  input  wire logic [15:0]      instr_ptr,
  input  wire logic [15:0]      effective_address,
  input  wire logic [2:0]       dest_sel,
  input  wire logic [15:0]      frame_base_ptr,
  input  wire logic             overflow_flag,
  input  wire logic             parity_flag,
  input  wire logic             sign_flag,
  input  wire logic             zero_flag,
  input  wire logic             aux_carry_flag,
  input  wire logic             carry_flag,
  input  wire logic [15:0]      mem_rd_data,
  input  wire logic             mem_rd_ack,
  output logic                  busy_q,
  output logic                  done_q,
  output logic                  mem_rd_req_q,
  output logic [15:0]           mem_addr_q,
  output logic                  instr_ptr_we_q,
  output logic                  jump_taken_q,
  output logic [15:0]           instr_ptr_new_q,
  output logic                  gp_we_q,
  output logic [2:0]            gp_sel_q,
  output logic [15:0]           gp_data_q,
  output logic                  high_acc_we_q,
  output logic [7:0]            high_acc_byte_q,
  output logic                  data_segment_we_q,
  output logic [15:0]           data_segment_reg_q,
  output logic                  frame_base_we_q,
  output logic [15:0]           frame_base_new_q,
  output logic                  stack_ptr_we_q,
  output logic [15:0]           stack_ptr_new_q,
  output logic                  flags_we_q
);

  // ----------------------------------------
  // sub-units
  // ----------------------------------------
  cjl_xu_if xu ();
  logic        rd_start;
  logic [15:0] rd_addr;

  assign xu.op                 = issue_op;
  assign xu.overflow_flag      = overflow_flag;
  assign xu.parity_flag        = parity_flag;
  assign xu.sign_flag          = sign_flag;
  assign xu.instr_ptr          = instr_ptr;
  assign xu.short_displacement = short_displacement;
  assign xu.rd_start           = rd_start;
  assign xu.rd_addr            = rd_addr;

  cjl_branch u_branch (
    .xu (xu.br)
  );

  cjl_word_rd u_rd (
    .clk          (clk),
    .rst          (rst),
    .xu           (xu.rd),
    .mem_rd_req_q (mem_rd_req_q),
    .mem_addr_q   (mem_addr_q),
    .mem_rd_data  (mem_rd_data),
    .mem_rd_ack   (mem_rd_ack)
  );

  // ----------------------------------------
  // sequencer state
  // ----------------------------------------
  cjl_pkg::cjl_state_t state_d, state_q;
  logic [15:0]         addr_d, addr_q;
  logic [15:0]         lo_d, lo_q;
  logic [2:0]          dest_d, dest_q;
  logic                busy_d, done_d;
  logic                ip_we_d, taken_d;
  logic [15:0]         ip_new_d;
  logic                gp_we_d;
  logic [2:0]          gp_sel_d;
  logic [15:0]         gp_data_d;
  logic                ha_we_d;
  logic [7:0]          ha_d;
  logic                ds_we_d;
  logic [15:0]         ds_d;
  logic                fb_we_d;
  logic [15:0]         fb_d;
  logic                st_we_d;
  logic [15:0]         st_d;
  logic                accept;

  // new work is taken only while idle; a busy core ignores issue
  assign accept = issue_valid && (state_q == cjl_pkg::ST_IDLE);

  always_comb begin
    state_d   = state_q;
    addr_d    = addr_q;
    lo_d      = lo_q;
    dest_d    = dest_q;
    busy_d    = busy_q;
    done_d    = 1'b0;
    ip_we_d   = 1'b0;
    taken_d   = 1'b0;
    ip_new_d  = instr_ptr_new_q;
    gp_we_d   = 1'b0;
    gp_sel_d  = gp_sel_q;
    gp_data_d = gp_data_q;
    ha_we_d   = 1'b0;
    ha_d      = high_acc_byte_q;
    ds_we_d   = 1'b0;
    ds_d      = data_segment_reg_q;
    fb_we_d   = 1'b0;
    fb_d      = frame_base_new_q;
    st_we_d   = 1'b0;
    st_d      = stack_ptr_new_q;
    rd_start  = 1'b0;
    rd_addr   = addr_q;
    unique case (state_q)
      cjl_pkg::ST_IDLE: begin
        if (accept) begin
          unique case (issue_op)
            cjl_pkg::OP_JUMP_IF_OVERFLOW,
            cjl_pkg::OP_JUMP_IF_PARITY,
            cjl_pkg::OP_JUMP_IF_PARITY_EVEN,
            cjl_pkg::OP_JUMP_IF_SIGN: begin
              ip_we_d  = 1'b1;
              taken_d  = xu.taken;
              ip_new_d = xu.target;
              done_d   = 1'b1;
            end
            cjl_pkg::OP_FLAGS_TO_HIGH_ACC: begin
              // undefined positions are driven as a fixed fill
              ha_d                = `CJL_HA_FILL;
              ha_d[`CJL_HA_SIGN]  = sign_flag;
              ha_d[`CJL_HA_ZERO]  = zero_flag;
              ha_d[`CJL_HA_AUX]   = aux_carry_flag;
              ha_d[`CJL_HA_PAR]   = parity_flag;
              ha_d[`CJL_HA_CARRY] = carry_flag;
              ha_we_d             = 1'b1;
              done_d              = 1'b1;
            end
            cjl_pkg::OP_LOAD_EFF_ADDR: begin
              // the offset itself is the result; memory is not touched
              gp_we_d   = 1'b1;
              gp_sel_d  = dest_sel;
              gp_data_d = effective_address;
              done_d    = 1'b1;
            end
            cjl_pkg::OP_LOAD_FAR_PTR_DATA_SEG: begin
              // the operand is always a memory address, never a register
              addr_d   = effective_address;
              dest_d   = dest_sel;
              rd_start = 1'b1;
              rd_addr  = effective_address;
              busy_d   = 1'b1;
              state_d  = cjl_pkg::ST_PTR_LO;
            end
            cjl_pkg::OP_FRAME_TEARDOWN: begin
              st_we_d  = 1'b1;
              st_d     = frame_base_ptr;
              addr_d   = frame_base_ptr;
              rd_start = 1'b1;
              rd_addr  = frame_base_ptr;
              busy_d   = 1'b1;
              state_d  = cjl_pkg::ST_POP;
            end
          endcase
        end
      end
      cjl_pkg::ST_PTR_LO: begin
        if (xu.rd_valid) begin
          lo_d     = xu.rd_word;
          addr_d   = addr_q + `CJL_SEG_OFS;
          rd_start = 1'b1;
          rd_addr  = addr_q + `CJL_SEG_OFS;
          state_d  = cjl_pkg::ST_PTR_HI;
        end
      end
      cjl_pkg::ST_PTR_HI: begin
        if (xu.rd_valid) begin
          // both halves land together so no half-loaded pointer is seen
          gp_we_d   = 1'b1;
          gp_sel_d  = dest_q;
          gp_data_d = lo_q;
          ds_we_d   = 1'b1;
          ds_d      = xu.rd_word;
          done_d    = 1'b1;
          busy_d    = 1'b0;
          state_d   = cjl_pkg::ST_IDLE;
        end
      end
      cjl_pkg::ST_POP: begin
        if (xu.rd_valid) begin
          fb_we_d = 1'b1;
          fb_d    = xu.rd_word;
          st_we_d = 1'b1;
          st_d    = addr_q + `CJL_POP_INC;
          done_d  = 1'b1;
          busy_d  = 1'b0;
          state_d = cjl_pkg::ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q            <= cjl_pkg::ST_IDLE;
      addr_q             <= `CJL_RST16;
      lo_q               <= `CJL_RST16;
      dest_q             <= `CJL_RST3;
      busy_q             <= 1'b0;
      done_q             <= 1'b0;
      instr_ptr_we_q     <= 1'b0;
      jump_taken_q       <= 1'b0;
      instr_ptr_new_q    <= `CJL_RST16;
      gp_we_q            <= 1'b0;
      gp_sel_q           <= `CJL_RST3;
      gp_data_q          <= `CJL_RST16;
      high_acc_we_q      <= 1'b0;
      high_acc_byte_q    <= `CJL_RST8;
      data_segment_we_q  <= 1'b0;
      data_segment_reg_q <= `CJL_RST16;
      frame_base_we_q    <= 1'b0;
      frame_base_new_q   <= `CJL_RST16;
      stack_ptr_we_q     <= 1'b0;
      stack_ptr_new_q    <= `CJL_RST16;
      flags_we_q         <= 1'b0;
    end else begin
      state_q            <= state_d;
      addr_q             <= addr_d;
      lo_q               <= lo_d;
      dest_q             <= dest_d;
      busy_q             <= busy_d;
      done_q             <= done_d;
      instr_ptr_we_q     <= ip_we_d;
      jump_taken_q       <= taken_d;
      instr_ptr_new_q    <= ip_new_d;
      gp_we_q            <= gp_we_d;
      gp_sel_q           <= gp_sel_d;
      gp_data_q          <= gp_data_d;
      high_acc_we_q      <= ha_we_d;
      high_acc_byte_q    <= ha_d;
      data_segment_we_q  <= ds_we_d;
      data_segment_reg_q <= ds_d;
      frame_base_we_q    <= fb_we_d;
      frame_base_new_q   <= fb_d;
      stack_ptr_we_q     <= st_we_d;
      stack_ptr_new_q    <= st_d;
      // the flag register is never written by this block
      flags_we_q         <= 1'b0;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [15:0] chk_taken_tgt, chk_next;
  logic        chk_jump;
  assign chk_next      = instr_ptr + `CJL_INSTR_LEN;
  assign chk_taken_tgt = chk_next + {{8{short_displacement[7]}}, short_displacement};
  assign chk_jump      = accept && (issue_op inside {cjl_pkg::OP_JUMP_IF_OVERFLOW,
                         cjl_pkg::OP_JUMP_IF_PARITY, cjl_pkg::OP_JUMP_IF_PARITY_EVEN,
                         cjl_pkg::OP_JUMP_IF_SIGN});

  a_jump_overflow: assert property (@(posedge clk) disable iff (rst)
    accept && issue_op == cjl_pkg::OP_JUMP_IF_OVERFLOW
      |=> instr_ptr_we_q && jump_taken_q == $past(overflow_flag))
    else $error("overflow jump decision wrong");
  a_jump_parity: assert property (@(posedge clk) disable iff (rst)
    accept && (issue_op == cjl_pkg::OP_JUMP_IF_PARITY
               || issue_op == cjl_pkg::OP_JUMP_IF_PARITY_EVEN)
      |=> instr_ptr_we_q && jump_taken_q == $past(parity_flag))
    else $error("parity jump decision wrong");
  a_jump_sign: assert property (@(posedge clk) disable iff (rst)
    accept && issue_op == cjl_pkg::OP_JUMP_IF_SIGN
      |=> instr_ptr_we_q && jump_taken_q == $past(sign_flag))
    else $error("sign jump decision wrong");
  a_taken_target: assert property (@(posedge clk) disable iff (rst)
    chk_jump && xu.taken |=> instr_ptr_new_q == $past(chk_taken_tgt))
    else $error("taken jump target wrong");
  a_fall_through: assert property (@(posedge clk) disable iff (rst)
    chk_jump && !xu.taken |=> !jump_taken_q && instr_ptr_new_q == $past(chk_next))
    else $error("untaken jump target wrong");
  a_high_acc_bits: assert property (@(posedge clk) disable iff (rst)
    accept && issue_op == cjl_pkg::OP_FLAGS_TO_HIGH_ACC |=> high_acc_we_q
      && high_acc_byte_q[7] == $past(sign_flag) && high_acc_byte_q[6] == $past(zero_flag)
      && high_acc_byte_q[4] == $past(aux_carry_flag)
      && high_acc_byte_q[2] == $past(parity_flag) && high_acc_byte_q[0] == $past(carry_flag))
    else $error("flag copy into high byte wrong");
  a_high_acc_fill: assert property (@(posedge clk) disable iff (rst)
    high_acc_we_q |-> !high_acc_byte_q[5] && !high_acc_byte_q[3] && !high_acc_byte_q[1])
    else $error("undefined high byte bits not zero filled");
  a_far_ptr_reads: assert property (@(posedge clk) disable iff (rst)
    accept && issue_op == cjl_pkg::OP_LOAD_FAR_PTR_DATA_SEG
      |=> mem_rd_req_q && mem_addr_q == $past(effective_address))
    else $error("far pointer read not at effective address");
  a_far_ptr_pair: assert property (@(posedge clk) disable iff (rst)
    data_segment_we_q |-> gp_we_q && gp_sel_q == dest_q && done_q)
    else $error("far pointer halves not written together");
  a_eff_addr_noread: assert property (@(posedge clk) disable iff (rst)
    accept && issue_op == cjl_pkg::OP_LOAD_EFF_ADDR
      |=> gp_we_q && gp_data_q == $past(effective_address) && !mem_rd_req_q)
    else $error("effective address load wrong");
  a_teardown_copy: assert property (@(posedge clk) disable iff (rst)
    accept && issue_op == cjl_pkg::OP_FRAME_TEARDOWN |=> stack_ptr_we_q
      && stack_ptr_new_q == $past(frame_base_ptr) && mem_addr_q == $past(frame_base_ptr))
    else $error("teardown stack copy wrong");
  a_teardown_pop: assert property (@(posedge clk) disable iff (rst)
    frame_base_we_q |-> stack_ptr_we_q && stack_ptr_new_q == addr_q + `CJL_POP_INC)
    else $error("teardown pop step wrong");
  a_flags_untouched: assert property (@(posedge clk) disable iff (rst)
    done_q |-> !flags_we_q)
    else $error("flag write seen");

endmodule

/* hdl/cjl_pkg.sv */
// Purpose: types of the conditional jump and load execution block
// Assumes: nothing
// Notes:   no constants here, see cjl_defs.svh
package cjl_pkg;

  typedef enum logic [2:0] {
    OP_JUMP_IF_OVERFLOW,
    OP_JUMP_IF_PARITY,
    OP_JUMP_IF_PARITY_EVEN,
    OP_JUMP_IF_SIGN,
    OP_FLAGS_TO_HIGH_ACC,
    OP_LOAD_FAR_PTR_DATA_SEG,
    OP_LOAD_EFF_ADDR,
    OP_FRAME_TEARDOWN
  } cjl_op_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PTR_LO,
    ST_PTR_HI,
    ST_POP
  } cjl_state_t;

endpackage

/* hdl/cjl_word_rd.sv */
// Purpose: single-word data read toward the memory side
// Assumes: mem_rd_ack comes from logic on clk
// Notes:   one read outstanding at a time
`include "cjl_defs.svh"

module cjl_word_rd (
  input  wire logic        clk,
  input  wire logic        rst,
  cjl_xu_if.rd             xu,
  output logic             mem_rd_req_q,
  output logic [15:0]      mem_addr_q,
  input  wire logic [15:0] mem_rd_data,
  input  wire logic        mem_rd_ack
);

  logic        req_d;
  logic [15:0] addr_d;
  logic [15:0] word_d;
  logic [15:0] word_q;
  logic        valid_d;
  logic        valid_q;

  always_comb begin
    req_d   = mem_rd_req_q;
    addr_d  = mem_addr_q;
    word_d  = word_q;
    valid_d = 1'b0;
    if (mem_rd_req_q && mem_rd_ack) begin
      req_d   = 1'b0;
      word_d  = mem_rd_data;
      valid_d = 1'b1;
    end
    // start is only given while no read is open
    if (xu.rd_start) begin
      req_d  = 1'b1;
      addr_d = xu.rd_addr;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_rd_req_q <= 1'b0;
      mem_addr_q   <= `CJL_RST16;
      word_q       <= `CJL_RST16;
      valid_q      <= 1'b0;
    end else begin
      mem_rd_req_q <= req_d;
      mem_addr_q   <= addr_d;
      word_q       <= word_d;
      valid_q      <= valid_d;
    end
  end

  assign xu.rd_word  = word_q;
  assign xu.rd_valid = valid_q;

endmodule

/* hdl/cjl_xu_if.sv */
// Purpose: carrier between the execution core, branch unit and word reader
// Assumes: one clock domain
// Notes:   none
interface cjl_xu_if;
  cjl_pkg::cjl_op_t op;
  logic             overflow_flag;
  logic             parity_flag;
  logic             sign_flag;
  logic [15:0]      instr_ptr;
  logic [7:0]       short_displacement;
  logic             taken;
  logic [15:0]      target;
  logic             rd_start;
  logic [15:0]      rd_addr;
  logic [15:0]      rd_word;
  logic             rd_valid;

  modport br (
    input  op,
    input  overflow_flag,
    input  parity_flag,
    input  sign_flag,
    input  instr_ptr,
    input  short_displacement,
    output taken,
    output target
  );

  modport rd (
    input  rd_start,
    input  rd_addr,
    output rd_word,
    output rd_valid
  );
endinterface
